/* File: acq_cmd_map.svh */
`ifndef ACQ_CMD_MAP_SVH
`define ACQ_CMD_MAP_SVH

// ************************************************************
// command identifiers
// ************************************************************
`define CMD_MODE_WR 16'h0003
`define CMD_MODE_RD 16'h0004
`define CMD_STG_WR 16'h0005
`define CMD_STG_RD 16'h0006
`define CMD_ACQ_ACT 16'h0007
`define CMD_ACQ_STAT 16'h0008
`define CMD_TRIG_MASK 16'h0009
`define CMD_TDC_WR 16'h0101
`define CMD_TDC_RD 16'h0102
`define CMD_ADC_RST 16'h0103
`define CMD_ADC_WR 16'h0104
`define CMD_DAC_WR 16'h0106
`define CMD_FWTH_WR 16'h0108
`define CMD_FWTH_RD 16'h0109

// ************************************************************
// target word fields
// ************************************************************
`define TGT_BCAST_BIT 15
`define TGT_IDX_MSB 3

// ************************************************************
// payload values
// ************************************************************
`define MODE_OSC_VAL 32'h00000001
`define MODE_SNG_VAL 32'h00000002
`define ACT_RESET_VAL 32'h00000000
`define ACT_STOP_VAL 32'h00000001
`define ACT_RUN_VAL 32'h00000002
`define TDC_RST_BIT 7
`define TDC_CAL_BIT 1
`define TDC_RUN_BIT 2

// ************************************************************
// oscilloscope and singles settings field positions
// ************************************************************
// window in the top byte, down to format in the bottom byte
`define OSC_WIN_LSB 24
`define OSC_BTG_LSB 16
`define OSC_SMP_LSB 8
`define OSC_FMT_LSB 0
`define SNG_INT_MSB 7

// ************************************************************
// reset values and answer codes
// ************************************************************
`define STAT_STOPPED 32'h00000001
`define STAT_RUNNING 32'h00000002
`define UNKNOWN_PLD 32'hFFFFFFFF
`define MASK_RST 32'h00000000

`endif

/* File: acq_cmd_pkg.sv */
package acq_cmd_pkg;
    // acquisition mode held by the board
    typedef enum logic [1:0] {
        mode_idle,
        mode_osc,
        mode_sng
    } acq_mode_t;
    // run state of the datapath
    typedef enum logic [1:0] {
        act_reset,
        act_stop,
        act_run
    } acq_act_t;
endpackage

/* File: acquisition_command_decoder.sv */
`timescale 1ns/100ps
`include "acq_cmd_map.svh"
// What this block does
// - target top bit broadcasts, low bits pick board
// - mode write payload one selects oscilloscope
// - mode write payload two selects singles
// - mode read answers on any board
// - settings write stores 32-bit payload
// - settings read returns stored settings
// - oscilloscope settings split into four fields
// - singles settings give integration sample count
// - action zero clears datapath buffers and registers
// - acquisition reset keeps ADC and DAC config
// - action two starts or resumes acquisition
// - action one pauses, FIFOs kept
// - status read shows whether acquisition stopped
// - trigger mask write sets channel enables
// - converter control bits reset, calibrate, run
// - converter control read returns its register
// - ADC write forwards payload to ADC chips
// - ADC reset command resets external ADCs
// - DAC write forwards threshold payload
// - firmware threshold write stores, read returns
module acquisition_command_decoder
    import acq_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // board identity
    input wire logic [3:0] board_index,
    // command in
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_id,
    input wire logic [15:0] cmd_target,
    input wire logic [31:0] cmd_payload,
    // response out
    output logic rsp_valid_reg,
    output logic [15:0] rsp_id_reg,
    output logic [15:0] rsp_src_reg,
    output logic [15:0] rsp_dst_reg,
    output logic [31:0] rsp_payload_reg,
    output logic rsp_unknown_reg,
    // acquisition control
    output logic [1:0] mode_reg,
    output logic [31:0] settings_reg,
    output logic [7:0] osc_window_reg,
    output logic [7:0] osc_pretrig_reg,
    output logic [7:0] osc_samples_reg,
    output logic [7:0] osc_format_reg,
    output logic [7:0] sng_int_samples_reg,
    output logic acq_run_reg,
    output logic dp_clear_reg,
    // trigger and converter control
    output logic [31:0] trig_mask_reg,
    output logic [31:0] tdc_ctrl_reg,
    output logic tdc_reset_reg,
    output logic tdc_cal_reg,
    output logic tdc_running_reg,
    // external parts and threshold
    output logic adc_wr_reg,
    output logic [31:0] adc_data_reg,
    output logic adc_reset_reg,
    output logic dac_wr_reg,
    output logic [31:0] dac_data_reg,
    output logic [31:0] fw_thresh_reg,
    // datapath status
    input wire logic acq_idle
);

    // ********************************************************
    // addressing
    // ********************************************************
    logic hit; // command is for this board
    logic known; // identifier recognised
    logic wr_hit; // recognised command acting here

    // broadcast flag or matching board index
    always_comb begin
        hit = cmd_target[`TGT_BCAST_BIT] ||
              (cmd_target[`TGT_IDX_MSB:0] == board_index);
    end

    // recognised identifiers
    always_comb begin
        case (cmd_id)
            `CMD_MODE_WR, `CMD_MODE_RD, `CMD_STG_WR, `CMD_STG_RD,
            `CMD_ACQ_ACT, `CMD_ACQ_STAT, `CMD_TRIG_MASK, `CMD_TDC_WR,
            `CMD_TDC_RD, `CMD_ADC_RST, `CMD_ADC_WR, `CMD_DAC_WR,
            `CMD_FWTH_WR, `CMD_FWTH_RD: known = 1'b1;
            default: known = 1'b0;
        endcase
        wr_hit = cmd_valid && hit && known;
    end

    // ********************************************************
    // configuration state
    // ********************************************************
    acq_mode_t mode_next;
    acq_act_t act_reg;
    acq_act_t act_next;
    logic [31:0] settings_next;
    logic [31:0] trig_mask_next;
    logic [31:0] tdc_ctrl_next;
    logic [31:0] fw_thresh_next;

    // next configuration from decoded writes
    always_comb begin
        mode_next = acq_mode_t'(mode_reg);
        act_next = act_reg;
        settings_next = settings_reg;
        trig_mask_next = trig_mask_reg;
        tdc_ctrl_next = tdc_ctrl_reg;
        fw_thresh_next = fw_thresh_reg;
        if (wr_hit) begin
            case (cmd_id)
                `CMD_MODE_WR: begin
                    if (cmd_payload == `MODE_OSC_VAL) begin
                        mode_next = mode_osc;
                    end else if (cmd_payload == `MODE_SNG_VAL) begin
                        mode_next = mode_sng;
                    end
                end
                `CMD_STG_WR: settings_next = cmd_payload;
                `CMD_ACQ_ACT: begin
                    if (cmd_payload == `ACT_RESET_VAL) begin
                        act_next = act_reset;
                    end else if (cmd_payload == `ACT_STOP_VAL) begin
                        act_next = act_stop;
                    end else if (cmd_payload == `ACT_RUN_VAL) begin
                        act_next = act_run;
                    end
                end
                `CMD_TRIG_MASK: trig_mask_next = cmd_payload;
                `CMD_TDC_WR: tdc_ctrl_next = cmd_payload;
                `CMD_FWTH_WR: fw_thresh_next = cmd_payload;
                default: begin
                    // reads leave configuration alone
                end
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // back to power-up configuration
            mode_reg <= 2'h0;
            act_reg <= act_reset;
            settings_reg <= 32'h00000000;
            trig_mask_reg <= `MASK_RST;
            tdc_ctrl_reg <= 32'h00000000;
            fw_thresh_reg <= 32'h00000000;
        end else begin
            // take the decoded configuration
            mode_reg <= mode_next;
            act_reg <= act_next;
            settings_reg <= settings_next;
            trig_mask_reg <= trig_mask_next;
            tdc_ctrl_reg <= tdc_ctrl_next;
            fw_thresh_reg <= fw_thresh_next;
        end
    end

    // ********************************************************
    // decoded control outputs
    // ********************************************************
    logic [7:0] osc_w_next; // trigger window field
    logic [7:0] osc_b_next; // samples before trigger field
    logic [7:0] osc_s_next; // total sample count field
    logic [7:0] osc_f_next; // output format field
    logic [7:0] sng_next; // singles integration count
    logic run_next; // acquisition running
    logic clr_next; // datapath clear pulse
    logic trst_next; // converter reset level
    logic tcal_next; // converter calibrate level
    logic trun_next; // converter run level
    logic adc_wr_next; // ADC write strobe
    logic adc_rst_next; // ADC reset strobe
    logic dac_wr_next; // DAC write strobe
    logic [31:0] adc_data_next; // word for the ADC chips
    logic [31:0] dac_data_next; // word for the threshold DAC

    // field split, strobes and external forwarding
    always_comb begin
        // window high byte down to format low byte
        osc_w_next = settings_next[`OSC_WIN_LSB +: 8];
        osc_b_next = settings_next[`OSC_BTG_LSB +: 8];
        osc_s_next = settings_next[`OSC_SMP_LSB +: 8];
        osc_f_next = settings_next[`OSC_FMT_LSB +: 8];
        sng_next = settings_next[`SNG_INT_MSB:0];
        run_next = (act_next == act_run);
        // one-cycle clear; ADC/DAC config lives outside it
        clr_next = wr_hit && (cmd_id == `CMD_ACQ_ACT) &&
                   (cmd_payload == `ACT_RESET_VAL);
        trst_next = tdc_ctrl_next[`TDC_RST_BIT];
        tcal_next = tdc_ctrl_next[`TDC_CAL_BIT];
        trun_next = tdc_ctrl_next[`TDC_RUN_BIT];
        adc_wr_next = wr_hit && (cmd_id == `CMD_ADC_WR);
        adc_rst_next = wr_hit && (cmd_id == `CMD_ADC_RST);
        dac_wr_next = wr_hit && (cmd_id == `CMD_DAC_WR);
        adc_data_next = adc_wr_next ? cmd_payload : adc_data_reg;
        dac_data_next = dac_wr_next ? cmd_payload : dac_data_reg;
    end

    // control output registers; acquisition reset only pulses dp_clear_reg and drops acq_run_reg
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // all strobes low, fields zero
            osc_window_reg <= 8'h00;
            osc_pretrig_reg <= 8'h00;
            osc_samples_reg <= 8'h00;
            osc_format_reg <= 8'h00;
            sng_int_samples_reg <= 8'h00;
            acq_run_reg <= 1'b0;
            dp_clear_reg <= 1'b0;
            tdc_reset_reg <= 1'b0;
            tdc_cal_reg <= 1'b0;
            tdc_running_reg <= 1'b0;
            adc_wr_reg <= 1'b0;
            adc_reset_reg <= 1'b0;
            dac_wr_reg <= 1'b0;
            adc_data_reg <= 32'h00000000;
            dac_data_reg <= 32'h00000000;
        end else begin
            // register every decoded output
            osc_window_reg <= osc_w_next;
            osc_pretrig_reg <= osc_b_next;
            osc_samples_reg <= osc_s_next;
            osc_format_reg <= osc_f_next;
            sng_int_samples_reg <= sng_next;
            acq_run_reg <= run_next;
            dp_clear_reg <= clr_next;
            tdc_reset_reg <= trst_next;
            tdc_cal_reg <= tcal_next;
            tdc_running_reg <= trun_next;
            adc_wr_reg <= adc_wr_next;
            adc_reset_reg <= adc_rst_next;
            dac_wr_reg <= dac_wr_next;
            adc_data_reg <= adc_data_next;
            dac_data_reg <= dac_data_next;
        end
    end

    // ********************************************************
    // response
    // ********************************************************
    logic [31:0] rd_val; // value placed in the answer
    logic rsp_v_next; // answer present
    logic rsp_u_next; // identifier not recognised
    logic [15:0] rsp_i_next; // echoed identifier
    logic [15:0] rsp_s_next; // source board word
    logic [15:0] rsp_d_next; // echoed destination

    // read mux and answer build
    always_comb begin
        case (cmd_id)
            `CMD_MODE_RD: rd_val = {30'h0, mode_reg};
            `CMD_STG_RD: rd_val = settings_reg;
            `CMD_ACQ_STAT: begin
                // stopped only when not running and datapath idle
                rd_val = (!acq_run_reg && acq_idle) ?
                         `STAT_STOPPED : `STAT_RUNNING;
            end
            `CMD_TDC_RD: rd_val = tdc_ctrl_reg;
            `CMD_FWTH_RD: rd_val = fw_thresh_reg;
            default: rd_val = known ? cmd_payload : `UNKNOWN_PLD;
        endcase
        // mode read answered even when not addressed
        rsp_v_next = cmd_valid &&
                     (hit || (cmd_id == `CMD_MODE_RD));
        rsp_u_next = rsp_v_next && !known;
        rsp_i_next = cmd_id;
        rsp_s_next = {12'h000, board_index};
        rsp_d_next = cmd_target;
    end

    // answer registers; payload and header held until next answer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // no answer pending
            rsp_valid_reg <= 1'b0;
            rsp_unknown_reg <= 1'b0;
            rsp_id_reg <= 16'h0000;
            rsp_src_reg <= 16'h0000;
            rsp_dst_reg <= 16'h0000;
            rsp_payload_reg <= 32'h00000000;
        end else begin
            // strobe every cycle, fields only with an answer
            rsp_valid_reg <= rsp_v_next;
            rsp_unknown_reg <= rsp_u_next;
            if (rsp_v_next) begin
                rsp_id_reg <= rsp_i_next;
                rsp_src_reg <= rsp_s_next;
                rsp_dst_reg <= rsp_d_next;
                rsp_payload_reg <= rd_val;
            end
        end
    end

endmodule

/* File: acq_cmd_checker.sv */
`timescale 1ns/100ps
`include "acq_cmd_map.svh"
// *****
// decoder port checks
// *****
module acq_cmd_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // command side
    input wire logic [3:0] board_index,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_id,
    input wire logic [15:0] cmd_target,
    input wire logic [31:0] cmd_payload,
    // answer and control side
    input wire logic rsp_valid_reg,
    input wire logic [15:0] rsp_id_reg,
    input wire logic [1:0] mode_reg,
    input wire logic [31:0] settings_reg,
    input wire logic [7:0] osc_format_reg,
    input wire logic acq_run_reg,
    input wire logic dp_clear_reg,
    input wire logic adc_wr_reg,
    input wire logic [31:0] adc_data_reg,
    input wire logic [31:0] dac_data_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // command addressed to this board
    logic hit;
    // acquisition action addressed here
    logic act;
    assign hit = cmd_valid &&
        (cmd_target[15] || cmd_target[3:0] == board_index);
    assign act = hit && cmd_id == `CMD_ACQ_ACT;
    // lone reset action, then a one-cycle clear
    sequence s_rst_cmd;
        act && cmd_payload == 32'h0 ##1 !cmd_valid;
    endsequence
    sequence s_clr_pulse;
        dp_clear_reg ##1 !dp_clear_reg;
    endsequence
    a_answer_next: assert property (hit |=> rsp_valid_reg)
        else $error("no answer");
    a_refuse_other: assert property (cmd_valid && !hit
        && cmd_id != `CMD_MODE_RD |=> !rsp_valid_reg)
        else $error("stray answer");
    a_echo_id: assert property (hit |=> rsp_id_reg == $past(cmd_id))
        else $error("id not echoed");
    a_mode_osc: assert property (hit && cmd_id == `CMD_MODE_WR
        && cmd_payload == 32'h1 |=> mode_reg == 2'h1)
        else $error("no osc mode");
    a_settings_store: assert property (hit && cmd_id == `CMD_STG_WR
        |=> settings_reg == $past(cmd_payload)) else $error("settings lost");
    a_osc_format: assert property (osc_format_reg == settings_reg[7:0])
        else $error("format field wrong");
    a_run_start: assert property (act && cmd_payload == 32'h2
        |=> acq_run_reg) else $error("run not started");
    a_stop_pause: assert property (act && cmd_payload == 32'h1
        |=> !acq_run_reg && !dp_clear_reg) else $error("stop wrong");
    a_clear_pulse: assert property (s_rst_cmd |-> s_clr_pulse)
        else $error("clear pulse wrong");
    a_ext_kept: assert property (act && cmd_payload == 32'h0
        |=> $stable(adc_data_reg) && $stable(dac_data_reg))
        else $error("ext lost");
    a_adc_forward: assert property (hit && cmd_id == `CMD_ADC_WR
        |=> adc_wr_reg && adc_data_reg == $past(cmd_payload))
        else $error("adc");
endmodule

bind acquisition_command_decoder acq_cmd_checker chk_u (.*);

/* File: acq_host_model.sv */
`timescale 1ns/100ps
// *****
// host command source
// *****
module acq_host_model #(
    parameter int CAL_WAIT = 8
) (
    // clock
    input wire logic clk,
    // command out
    output logic cmd_valid,
    output logic [15:0] cmd_id,
    output logic [15:0] cmd_target,
    output logic [31:0] cmd_payload
);
    initial begin
        cmd_valid = 1'b0;
        cmd_id = 16'h0000;
        cmd_target = 16'h0000;
        cmd_payload = 32'h00000000;
    end
    // one command held to its taking edge, fields scrambled after
    task send(input logic [15:0] id, tg, input logic [31:0] pl);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_id <= id;
        cmd_target <= tg;
        cmd_payload <= pl;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_id <= ~id;
        cmd_target <= ~tg;
        cmd_payload <= ~pl;
        #1;
    endtask
    // settle time after calibration, shortened
    task cal_wait;
        repeat (CAL_WAIT) @(posedge clk);
    endtask
endmodule

/* File: acquisition_command_decoder_bench.sv */
`timescale 1ns/100ps
`include "acq_cmd_map.svh"
module acquisition_command_decoder_bench;
    import acq_cmd_pkg::*;
    // *****
    // signals
    // *****
    logic clk, rst_b, acq_idle, cmd_valid, rsp_valid_reg, rsp_unknown_reg;
    logic acq_run_reg, dp_clear_reg, tdc_reset_reg, tdc_cal_reg;
    logic tdc_running_reg, adc_wr_reg, adc_reset_reg, dac_wr_reg;
    logic [1:0] mode_reg;
    logic [3:0] board_index;
    logic [7:0] osc_window_reg, osc_pretrig_reg, osc_samples_reg;
    logic [7:0] osc_format_reg, sng_int_samples_reg;
    logic [15:0] cmd_id, cmd_target, rsp_id_reg, rsp_src_reg, rsp_dst_reg, tgt;
    logic [31:0] cmd_payload, rsp_payload_reg, settings_reg, trig_mask_reg;
    logic [31:0] tdc_ctrl_reg, adc_data_reg, dac_data_reg, fw_thresh_reg;
    int n_fail = 0;
    int tests_run = 0;
    acquisition_command_decoder dut_u (.*);
    acq_host_model host_u (.*);
    always #10 clk = ~clk;
    // value compare
    task chk(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s exp %h got %h", what, exp, got);
        end
    endtask
    // write: answered next cycle with payload echoed
    task wr(input logic [15:0] id, input logic [31:0] pl);
        host_u.send(id, tgt, pl);
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid_reg});
        chk("rsp_payload", pl, rsp_payload_reg);
    endtask
    // read: answer carries id, source, target and value
    task rd(input logic [15:0] id, input logic [31:0] exp);
        host_u.send(id, tgt, 32'h0);
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid_reg});
        chk("rsp_id", {16'h0, id}, {16'h0, rsp_id_reg});
        chk("rsp_src", 32'h3, {16'h0, rsp_src_reg});
        chk("rsp_dst", {16'h0, tgt}, {16'h0, rsp_dst_reg});
        chk("rsp_payload", exp, rsp_payload_reg);
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // *****
    // sequence
    // *****
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        board_index = 4'h3;
        acq_idle = 1'b0;
        tgt = 16'h8003;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        wr(`CMD_MODE_WR, 32'h1);
        chk("mode", 32'h1, {30'h0, mode_reg});
        tgt = 16'h0001;
        rd(`CMD_MODE_RD, 32'h1);
        tgt = 16'h0003;
        wr(`CMD_STG_WR, 32'h02000101);
        chk("osc_win", 32'h2, {24'h0, osc_window_reg});
        chk("osc_btg", 32'h0, {24'h0, osc_pretrig_reg});
        chk("osc_smp_fmt", 32'h0101, {16'h0, osc_samples_reg,
            osc_format_reg});
        rd(`CMD_STG_RD, 32'h02000101);
        wr(`CMD_MODE_WR, 32'h2);
        chk("mode", 32'h2, {30'h0, mode_reg});
        wr(`CMD_STG_WR, 32'h6);
        chk("sng", 32'h6, {24'h0, sng_int_samples_reg});
        tgt = 16'h0005;
        host_u.send(`CMD_MODE_WR, tgt, 32'h1);
        chk("rsp_valid", 32'h0, {31'h0, rsp_valid_reg});
        chk("mode", 32'h2, {30'h0, mode_reg});
        tgt = 16'h8005;
        wr(`CMD_TRIG_MASK, 32'h0FFFFFFF);
        chk("mask", 32'h0FFFFFFF, trig_mask_reg);
        wr(`CMD_TDC_WR, 32'h80);
        chk("tdc_rst", 32'h1, {31'h0, tdc_reset_reg});
        wr(`CMD_TDC_WR, 32'h2);
        chk("tdc_cal", 32'h1, {31'h0, tdc_cal_reg});
        host_u.cal_wait;
        wr(`CMD_TDC_WR, 32'h4);
        chk("tdc_run", 32'h1, {31'h0, tdc_running_reg});
        rd(`CMD_TDC_RD, 32'h4);
        tgt = 16'h0003;
        wr(`CMD_ADC_WR, 32'h08A8CCCC);
        chk("adc_wr", 32'h1, {31'h0, adc_wr_reg});
        wr(`CMD_ADC_RST, 32'h0);
        chk("adc_rst", 32'h1, {31'h0, adc_reset_reg});
        wr(`CMD_DAC_WR, 32'h8007E032);
        chk("dac_wr", 32'h1, {31'h0, dac_wr_reg});
        chk("dac", 32'h8007E032, dac_data_reg);
        wr(`CMD_FWTH_WR, 32'h00000123);
        rd(`CMD_FWTH_RD, 32'h00000123);
        wr(`CMD_ACQ_ACT, 32'h2);
        chk("run", 32'h1, {31'h0, acq_run_reg});
        rd(`CMD_ACQ_STAT, `STAT_RUNNING);
        wr(`CMD_ACQ_ACT, 32'h1);
        chk("run", 32'h0, {31'h0, acq_run_reg});
        acq_idle <= 1'b1;
        rd(`CMD_ACQ_STAT, `STAT_STOPPED);
        wr(`CMD_ACQ_ACT, 32'h0);
        chk("clear", 32'h1, {31'h0, dp_clear_reg});
        chk("adc", 32'h08A8CCCC, adc_data_reg);
        chk("dac", 32'h8007E032, dac_data_reg);
        host_u.send(16'h0055, tgt, 32'h1);
        chk("unknown", 32'h1, {31'h0, rsp_unknown_reg});
        chk("rsp_payload", `UNKNOWN_PLD, rsp_payload_reg);
        chk("mode", 32'h2, {30'h0, mode_reg});
        tally_and_finish;
    end
endmodule
